//--- rtl/sss_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.vh"
module sss_slave #(
  parameter TIMEOUT_CYC = `SSS_TIMEOUT_MS * 1000 * `SSS_CLK_MHZ,
  parameter WRITE_CYC = `SSS_WRITE_MS * 1000 * `SSS_CLK_MHZ,
  parameter TO_W = 22,
  parameter WR_W = 19
) (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_pin_zero,
  input wire addr_pin_one,
  input wire addr_pin_two,
  input wire very_high_voltage_level,
  input wire [3:0] protect_flags,
  input wire [7:0] rd_data,
  output reg [7:0] sensor_ptr,
  output reg [7:0] ee_ptr,
  output reg bank_upper,
  output reg ee_wr_start,
  output reg [127:0] page_buf,
  output reg [15:0] page_mask,
  output reg sensor_wr,
  output reg [15:0] sensor_wr_data,
  output reg protect_set,
  output reg [1:0] protect_block,
  output reg protect_clear,
  output reg write_busy
);
  localparam ST_IDLE = 3'h0;
  localparam ST_RX = 3'h1;
  localparam ST_RACK = 3'h2;
  localparam ST_TX = 3'h3;
  localparam ST_TACK = 3'h4;
  localparam ST_WAIT = 3'h5;
  localparam K_NONE = 3'h0;
  localparam K_TS = 3'h1;
  localparam K_EE = 3'h2;
  localparam K_SWP = 3'h3;
  localparam K_CWP = 3'h4;
  localparam K_RPS = 3'h5;
  localparam K_SPA = 3'h6;
  localparam K_RPA = 3'h7;

  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  reg [2:0] st;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [1:0] byte_idx;
  reg [2:0] kind;
  reg rd;
  reg ackd;
  reg mack;
  reg spa_up;
  reg [1:0] ts_cnt;
  reg prot_ok;
  reg [TO_W-1:0] to_cnt;
  reg [WR_W-1:0] wr_cnt;
  reg [2:0] dk;
  reg [1:0] dblk;
  reg dack;
  reg [3:0] pre;
  reg [3:0] selrw;
  reg [3:0] strap_s1, strap_s2;

  // Two-stage synchronisers; only the second stage feeds logic
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      strap_s1 <= 4'h0;
      strap_s2 <= 4'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      // Address straps and the high-voltage detector are pins as well
      strap_s1 <= {very_high_voltage_level, addr_pin_two, addr_pin_one, addr_pin_zero};
      strap_s2 <= strap_s1;
    end
  end

  // Bus events; SDA moving under a high SCL is framing, not data
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire start_ev = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire stop_ev = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire timeout = ({{(32-TO_W){1'b0}}, to_cnt} >= TIMEOUT_CYC);
  wire [2:0] pins = strap_s2[2:0];
  wire hv_ok = strap_s2[3];

  // Decode of a just-received byte into command and acknowledge choice
  always @* begin
    pre = shreg[`SSS_PRE_HI:`SSS_PRE_LO];
    selrw = shreg[`SSS_SEL_HI:`SSS_RW_BIT];
    dk = K_NONE;
    dblk = 2'h0;
    dack = 1'b0;
    if (byte_idx == 2'h0) begin
      if ((pre == `SSS_PRE_SENSOR) && (selrw[3:1] == pins)) begin
        dk = K_TS;
      end else if ((pre == `SSS_PRE_EEPROM) && (selrw[3:1] == pins)) begin
        dk = K_EE;
      end else if (pre == `SSS_PRE_PROT) begin
        case (selrw)
          `SSS_PROT_BLK0_SET: begin dk = K_SWP; dblk = 2'h0; end
          `SSS_PROT_BLK1_SET: begin dk = K_SWP; dblk = 2'h1; end
          `SSS_PROT_BLK2_SET: begin dk = K_SWP; dblk = 2'h2; end
          `SSS_PROT_BLK3_SET: begin dk = K_SWP; dblk = 2'h3; end
          `SSS_PROT_CLEAR_ALL: dk = K_CWP;
          `SSS_PROT_BLK0_QRY: begin dk = K_RPS; dblk = 2'h0; end
          `SSS_PROT_BLK1_QRY: begin dk = K_RPS; dblk = 2'h1; end
          `SSS_PROT_BLK2_QRY: begin dk = K_RPS; dblk = 2'h2; end
          `SSS_PROT_BLK3_QRY: begin dk = K_RPS; dblk = 2'h3; end
          `SSS_PROT_BANK_LO: dk = K_SPA;
          `SSS_PROT_BANK_UP: dk = K_SPA;
          `SSS_PROT_BANK_QRY: dk = K_RPA;
          default: dk = K_NONE;
        endcase
      end
      case (dk)
        K_TS: dack = 1'b1;
        K_EE: dack = 1'b1;
        K_SWP: dack = ~protect_flags[dblk]; // Already protected: NoACK throughout
        K_RPS: dack = ~protect_flags[dblk];
        K_CWP: dack = 1'b1;
        K_SPA: dack = 1'b1;
        K_RPA: dack = ~bank_upper;
        default: dack = 1'b0;
      endcase
      if (write_busy) begin
        dack = 1'b0;
      end
    end else begin
      case (kind)
        K_TS: dack = 1'b1;
        K_EE: dack = 1'b1;
        K_SWP: dack = (byte_idx == 2'h1) | ((byte_idx == 2'h2) & hv_ok);
        K_CWP: dack = (byte_idx == 2'h1) | ((byte_idx == 2'h2) & hv_ok);
        K_SPA: dack = (byte_idx == 2'h1);
        default: dack = 1'b0;
      endcase
    end
  end

  // Internal write cycle timer; address bytes are refused while it runs
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_cnt <= {WR_W{1'b0}};
      write_busy <= 1'b0;
    end else if (ee_wr_start | protect_set | protect_clear) begin
      wr_cnt <= {WR_W{1'b0}};
      write_busy <= 1'b1;
    end else if (write_busy) begin
      wr_cnt <= wr_cnt + {{(WR_W-1){1'b0}}, 1'b1};
      write_busy <= ({{(32-WR_W){1'b0}}, wr_cnt} < (WRITE_CYC - 1));
    end
  end

  // Stuck-low SCL watchdog, counted only inside a transaction
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      to_cnt <= {TO_W{1'b0}};
    end else if ((st == ST_IDLE) || scl_s2 || timeout) begin
      to_cnt <= {TO_W{1'b0}};
    end else begin
      to_cnt <= to_cnt + {{(TO_W-1){1'b0}}, 1'b1};
    end
  end

  // Byte engine: shifts in on SCL rise, shifts out and changes SDA on SCL fall
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      byte_idx <= 2'h0;
      kind <= K_NONE;
      rd <= 1'b0;
      ackd <= 1'b0;
      mack <= 1'b0;
      spa_up <= 1'b0;
      ts_cnt <= 2'h0;
      prot_ok <= 1'b0;
      sda_out <= 1'b0; // Only ever pulls low; a one is a release
      sda_oe <= 1'b0;
      sensor_ptr <= `SSS_PTR_RST;
      ee_ptr <= `SSS_PTR_RST;
      bank_upper <= 1'b0;
      page_buf <= `SSS_BUF_RST;
      page_mask <= 16'h0000;
      sensor_wr_data <= 16'h0000;
      protect_block <= 2'h0;
      ee_wr_start <= 1'b0;
      sensor_wr <= 1'b0;
      protect_set <= 1'b0;
      protect_clear <= 1'b0;
    end else begin
      ee_wr_start <= 1'b0;
      sensor_wr <= 1'b0;
      protect_set <= 1'b0;
      protect_clear <= 1'b0;
      if (timeout) begin
        st <= ST_IDLE;
        sda_oe <= 1'b0;
        kind <= K_NONE;
      end else if (start_ev) begin
        st <= ST_RX;
        bitcnt <= 4'h0;
        byte_idx <= 2'h0;
        sda_oe <= 1'b0;
        ts_cnt <= 2'h0;
        prot_ok <= 1'b0;
        kind <= K_NONE; // Repeated START drops the aborted command
      end else if (stop_ev) begin
        st <= ST_IDLE;
        sda_oe <= 1'b0;
        // Commit happens only on STOP, never on a repeated START
        if (!rd && (kind == K_EE) && (page_mask != 16'h0000)) begin
          ee_wr_start <= 1'b1;
        end
        if (!rd && (kind == K_TS) && (ts_cnt == 2'h2)) begin
          sensor_wr <= 1'b1;
        end
        if (prot_ok && (kind == K_SWP)) begin
          protect_set <= 1'b1;
        end
        if (prot_ok && (kind == K_CWP)) begin
          protect_clear <= 1'b1;
        end
        kind <= K_NONE;
      end else begin
        case (st)
          ST_RX: begin
            if (scl_rise && (bitcnt != 4'h8)) begin
              shreg <= {shreg[6:0], sda_s2};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && (bitcnt == 4'h8)) begin
              st <= ST_RACK;
              sda_oe <= dack;
              ackd <= dack;
              if (byte_idx == 2'h0) begin
                kind <= dk;
                rd <= shreg[`SSS_RW_BIT];
                protect_block <= dblk;
                spa_up <= shreg[`SSS_SEL_LO];
                page_mask <= dack ? 16'h0000 : page_mask; // Stale bytes must not commit twice
              end else if (kind == K_TS) begin
                if (byte_idx == 2'h1) begin
                  sensor_ptr <= shreg;
                end else if (ts_cnt != 2'h2) begin
                  sensor_wr_data <= {sensor_wr_data[7:0], shreg};
                  ts_cnt <= ts_cnt + 2'h1;
                end
              end else if (kind == K_EE) begin
                if (byte_idx == 2'h1) begin
                  ee_ptr <= shreg;
                  page_mask <= 16'h0000;
                end else begin
                  page_buf[ee_ptr[3:0]*8 +: 8] <= shreg;
                  page_mask[ee_ptr[3:0]] <= 1'b1;
                  ee_ptr[3:0] <= ee_ptr[3:0] + 4'h1;
                end
              end else if ((kind == K_SWP) || (kind == K_CWP)) begin
                prot_ok <= dack & (byte_idx == 2'h2);
              end else if ((kind == K_SPA) && (byte_idx == 2'h2)) begin
                bank_upper <= spa_up;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (byte_idx != 2'h3) begin
                byte_idx <= byte_idx + 2'h1;
              end
              if (!ackd) begin
                st <= ST_WAIT;
                sda_oe <= 1'b0;
              end else if (rd && ((kind == K_TS) || (kind == K_EE))) begin
                st <= ST_TX;
                shreg <= rd_data;
                sda_oe <= ~rd_data[7];
              end else if (rd) begin
                // Status queries answer in the ack; data bytes are dummies
                st <= ST_TX;
                shreg <= 8'hff;
                sda_oe <= 1'b0;
              end else begin
                st <= ST_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && (bitcnt == 4'h8)) begin
              st <= ST_TACK;
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              if (kind == K_EE) begin
                ee_ptr <= ee_ptr + 8'h01;
              end
            end else if (scl_fall && (bitcnt != 4'h0)) begin
              shreg <= {shreg[6:0], 1'b1};
              sda_oe <= ~shreg[6];
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              mack <= ~sda_s2;
            end else if (scl_fall) begin
              if (mack && ((kind == K_TS) || (kind == K_EE))) begin
                st <= ST_TX;
                shreg <= rd_data;
                sda_oe <= ~rd_data[7];
              end else if (mack) begin
                st <= ST_TX;
                shreg <= 8'hff;
              end else begin
                st <= ST_WAIT;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0; // Idle or ignoring until next START
          end
        endcase
      end
    end
  end
endmodule // sss_slave
`default_nettype wire

//--- rtl/sss_map.vh
`ifndef SSS_MAP_VH
`define SSS_MAP_VH
// Clock rate and timing figures
`define SSS_CLK_MHZ 100
`define SSS_TIMEOUT_MS 25
`define SSS_WRITE_MS 5
// Address byte fields
`define SSS_PRE_HI 7
`define SSS_PRE_LO 4
`define SSS_SEL_HI 3
`define SSS_SEL_LO 1
`define SSS_RW_BIT 0
// Preamble codes
`define SSS_PRE_SENSOR 4'h3
`define SSS_PRE_EEPROM 4'ha
`define SSS_PRE_PROT 4'h6
// Protection-function {select, rw} codes
`define SSS_PROT_BLK0_SET 4'h2
`define SSS_PROT_BLK1_SET 4'h8
`define SSS_PROT_BLK2_SET 4'ha
`define SSS_PROT_BLK3_SET 4'h0
`define SSS_PROT_CLEAR_ALL 4'h6
`define SSS_PROT_BLK0_QRY 4'h3
`define SSS_PROT_BLK1_QRY 4'h9
`define SSS_PROT_BLK2_QRY 4'hb
`define SSS_PROT_BLK3_QRY 4'h1
`define SSS_PROT_BANK_LO 4'hc
`define SSS_PROT_BANK_UP 4'he
`define SSS_PROT_BANK_QRY 4'hd
// Reset values
`define SSS_PTR_RST 8'h00
`define SSS_BUF_RST 128'hffffffffffffffffffffffffffffffff
`endif

//--- test/sss_props.sv
`timescale 1ns/1ps
`default_nettype none
module sss_props #(
  parameter TIMEOUT_CYC = 200,
  parameter WRITE_CYC = 50
) (
  input wire ref_clk,
  input wire rst,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [7:0] ee_ptr,
  input wire [7:0] sensor_ptr,
  input wire bank_upper,
  input wire ee_wr_start,
  input wire sensor_wr,
  input wire protect_set,
  input wire protect_clear,
  input wire write_busy
);
  logic [31:0] busy_cnt;
  logic [31:0] low_cnt;
  // Busy length and raw SCL low time; the runs are short, so no saturation
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt <= 32'h0;
      low_cnt <= 32'h0;
    end else begin
      busy_cnt <= write_busy ? busy_cnt + 32'h1 : 32'h0;
      low_cnt <= scl_in ? 32'h0 : low_cnt + 32'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_RST_STATE: assert property ($fell(rst) |-> !bank_upper && ee_ptr == 8'h00 && sensor_ptr == 8'h00)
    else $error("bad state after reset");
  AST_EE_START: assert property (ee_wr_start |-> !write_busy ##1 write_busy && !ee_wr_start)
    else $error("eeprom write start wrong");
  AST_PROT_BUSY: assert property (protect_set || protect_clear |=> write_busy && !protect_set && !protect_clear)
    else $error("protect pulse wrong");
  AST_BUSY_LEN: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYC)
    else $error("busy length wrong");
  AST_QUIET_BUSY: assert property (write_busy |-> !sda_oe)
    else $error("acknowledge while busy");
  AST_DRIVE_ON_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed with scl high");
  AST_TIMEOUT: assert property (low_cnt > TIMEOUT_CYC + 8 |-> !sda_oe)
    else $error("sda held past timeout");
  AST_SENSOR_PULSE: assert property (sensor_wr |=> !sensor_wr && !ee_wr_start)
    else $error("sensor write pulse wrong");
  AST_PROT_EXCL: assert property (!(protect_set && protect_clear))
    else $error("set and clear together");
  C_EE: cover property (ee_wr_start);
  C_SENSOR: cover property (sensor_wr);
  C_CLEAR: cover property (protect_clear);
  C_BANK: cover property ($rose(bank_upper));
endmodule // sss_props
bind sss_slave sss_props #(.TIMEOUT_CYC(TIMEOUT_CYC), .WRITE_CYC(WRITE_CYC)) sss_props_inst (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .ee_ptr(ee_ptr), .sensor_ptr(sensor_ptr), .bank_upper(bank_upper),
  .ee_wr_start(ee_wr_start), .sensor_wr(sensor_wr), .protect_set(protect_set),
  .protect_clear(protect_clear), .write_busy(write_busy));
`default_nettype wire

//--- test/sss_master.sv
`timescale 1ns/1ps
`default_nettype none
module sss_master (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  // Bus idles released; SCL stands high outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit: data moves only while SCL is low, sampled while high
  task bit_x(input logic b, output logic r);
    #20 sda_low = ~b;
    #42.5 scl = 1'b1;
    #31 r = sda;
    #31.5 scl = 1'b0;
  endtask
  // Also serves as repeated start: releases SDA before raising SCL
  task start;
    #20 sda_low = 1'b0;
    #42.5 scl = 1'b1;
    #31 sda_low = 1'b1;
    #31.5 scl = 1'b0;
  endtask
  task stop;
    #20 sda_low = 1'b1;
    #42.5 scl = 1'b1;
    #31 sda_low = 1'b0;
  endtask
  task wbyte(input logic [7:0] d, output logic ack);
    logic r;
    integer i;
    for (i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Acknowledge low keeps the device sending; a release ends it
  task rbyte(input logic m_ack, output logic [7:0] d);
    logic r;
    integer i;
    for (i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~m_ack, r);
  endtask
endmodule // sss_master
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hv = 1'b0;
  logic [2:0] pins = 3'b101;
  logic [7:0] rd_byte = 8'h5a;
  logic [3:0] flags = 4'h0;
  logic sda_out, sda_oe, bank_upper, ee_wr_start, sensor_wr, protect_set, protect_clear;
  logic write_busy, scl, m_low, ack;
  logic [7:0] sensor_ptr, ee_ptr, d;
  logic [127:0] page_buf, exp_buf;
  logic [15:0] page_mask, sensor_wr_data;
  logic [1:0] protect_block, last_blk;
  logic [2:0] sel [0:4] = '{3'b001, 3'b100, 3'b101, 3'b000, 3'b011};
  logic [7:0] bad [0:3] = '{8'ha0, 8'h64, 8'h6f, 8'h5a};
  integer miscompares = 0, total_checks = 0, npr = 0, ncl = 0, nee = 0, nsw = 0, i;
  wire logic sda_w;
  // Pull-up on SDA: low while either party pulls
  assign sda_w = ~(sda_oe | m_low);
  always #5 ref_clk = ~ref_clk;
  // Write cycle long enough that a poll right after STOP lands inside it
  sss_slave #(.TIMEOUT_CYC(200), .WRITE_CYC(300)) sss_slave_inst (
    .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_pin_zero(pins[0]), .addr_pin_one(pins[1]), .addr_pin_two(pins[2]),
    .very_high_voltage_level(hv), .protect_flags(flags), .rd_data(rd_byte),
    .sensor_ptr(sensor_ptr), .ee_ptr(ee_ptr), .bank_upper(bank_upper),
    .ee_wr_start(ee_wr_start), .page_buf(page_buf), .page_mask(page_mask),
    .sensor_wr(sensor_wr), .sensor_wr_data(sensor_wr_data), .protect_set(protect_set),
    .protect_block(protect_block), .protect_clear(protect_clear), .write_busy(write_busy));
  sss_master sss_master_inst (.scl(scl), .sda_low(m_low), .sda(sda_w));
  // Count pulses so none is missed between polls
  always @(posedge ref_clk) begin
    if (protect_set === 1'b1) begin
      npr++;
      last_blk = protect_block;
    end
    if (protect_clear === 1'b1) ncl++;
    if (ee_wr_start === 1'b1) nee++;
    if (sensor_wr === 1'b1) nsw++;
  end
  task print_verdict;
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [127:0] g, input logic [127:0] e);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %0t got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask
  task send(input logic [7:0] b, input logic e);
    sss_master_inst.wbyte(b, ack);
    chk(ack, e);
  endtask
  // Bounded wait for the write cycle to finish
  task idle_wait;
    integer n;
    repeat (8) @(negedge ref_clk);
    for (n = 0; n < 400 && write_busy !== 1'b0; n++) @(negedge ref_clk);
    if (write_busy !== 1'b0) begin
      $display("ERROR %0t busy stuck", $time);
      miscompares++;
      print_verdict;
    end
  endtask
  // Watchdog against a hung run
  initial begin
    #900000;
    $display("ERROR %0t run timed out", $time);
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk({ee_ptr, sensor_ptr, bank_upper, write_busy}, 18'h0);
    chk(page_buf, {16{8'hff}});
    // Wrong pins, reserved codes, wrong preamble: no acknowledge
    for (i = 0; i < 4; i++) begin
      sss_master_inst.start;
      send(bad[i], 1'b0);
      sss_master_inst.stop;
    end
    // Pins move only between frames; the refused address now matches
    @(posedge ref_clk) #1 pins = 3'b000;
    sss_master_inst.start;
    send(8'ha0, 1'b1);
    sss_master_inst.stop;
    @(posedge ref_clk) #1 pins = 3'b101;
    // Page write of 18 bytes from position 5: the last seven wrap to position 0
    exp_buf = {16{8'hff}};
    sss_master_inst.start;
    send(8'haa, 1'b1);
    send(8'h35, 1'b1);
    for (i = 0; i < 18; i++) begin
      send(8'h10 + i[7:0], 1'b1);
      exp_buf[8 * ((5 + i) % 16) +: 8] = 8'h10 + i[7:0];
    end
    sss_master_inst.stop;
    repeat (8) @(negedge ref_clk);
    sss_master_inst.start;
    send(8'hab, 1'b0);
    sss_master_inst.stop;
    chk(nee, 1);
    chk({page_buf, page_mask, ee_ptr[7:4]}, {exp_buf, 16'hffff, 4'h3});
    idle_wait;
    // Address-only write, then loaded data aborted by a repeated START
    sss_master_inst.start;
    send(8'haa, 1'b1);
    sss_master_inst.stop;
    sss_master_inst.start;
    send(8'haa, 1'b1);
    send(8'h20, 1'b1);
    send(8'h77, 1'b1);
    sss_master_inst.start;
    sss_master_inst.stop;
    repeat (8) @(negedge ref_clk);
    chk({nee, write_busy}, {32'd1, 1'b0});
    sss_master_inst.start;
    send(8'h3a, 1'b1);
    send(8'h05, 1'b1);
    send(8'hab, 1'b1);
    send(8'hcd, 1'b1);
    sss_master_inst.stop;
    repeat (8) @(negedge ref_clk);
    chk({nsw, sensor_wr_data, sensor_ptr}, {32'd1, 16'habcd, 8'h05});
    // Every set code and the clear, with the high voltage present
    @(posedge ref_clk) #1 hv = 1'b1;
    for (i = 0; i < 5; i++) begin
      sss_master_inst.start;
      send({4'h6, sel[i], 1'b0}, 1'b1);
      send(8'h00, 1'b1);
      send(8'h00, 1'b1);
      sss_master_inst.stop;
      idle_wait;
      if (i < 4) chk({npr, last_blk}, {i + 1, i[1:0]});
      else chk(ncl, 1);
    end
    @(posedge ref_clk) #1 hv = 1'b0;
    sss_master_inst.start;
    send(8'h62, 1'b1);
    send(8'h00, 1'b1);
    send(8'h00, 1'b0);
    sss_master_inst.stop;
    repeat (8) @(negedge ref_clk);
    chk({npr, write_busy}, {32'd4, 1'b0});
    @(posedge ref_clk) #1 flags = 4'b0101;
    for (i = 0; i < 4; i++) begin
      sss_master_inst.start;
      send({4'h6, sel[i], 1'b1}, ~flags[i]);
      sss_master_inst.stop;
    end
    // Upper bank then back to lower, each followed by the query
    for (i = 1; i >= 0; i--) begin
      sss_master_inst.start;
      send(i ? 8'h6e : 8'h6c, 1'b1);
      send(8'h00, 1'b1);
      send(8'h00, 1'b0);
      sss_master_inst.stop;
      repeat (4) @(negedge ref_clk);
      chk(bank_upper, i[0]);
      sss_master_inst.start;
      send(8'h6d, ~i[0]);
      sss_master_inst.stop;
    end
    // Selective read across the top of the bank; read path changes between bytes
    sss_master_inst.start;
    send(8'haa, 1'b1);
    send(8'hfe, 1'b1);
    sss_master_inst.start;
    send(8'hab, 1'b1);
    sss_master_inst.rbyte(1'b1, d);
    @(posedge ref_clk) #1 rd_byte = 8'h3c;
    chk(d, 8'h5a);
    sss_master_inst.rbyte(1'b0, d);
    chk({d, ee_ptr}, {8'h3c, 8'h00});
    sss_master_inst.stop;
    // SCL held low while the device drives a zero
    sss_master_inst.start;
    send(8'hab, 1'b1);
    #200;
    chk(sda_oe, 1'b1);
    repeat (230) @(negedge ref_clk);
    chk(sda_oe, 1'b0);
    sss_master_inst.stop;
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
